/* File: verilog/ubb_pkg.sv */
// Purpose: shared constants for the byte-wide bit-bang parallel port
// Assumes: one 20 MHz clock, active-low asynchronous reset
// Notes: mode codes are the values carried by the mode-setup command
`default_nettype none
package ubb_pkg;
    localparam int unsigned WIDTH = 8;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_ASYNC = 8'h01;
    localparam logic [7:0] MODE_SYNC = 8'h04;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'hff;
    // internal clock and setup wait
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned SETUP_CLK = 1;
    // baud tick divisor default: one tick per this many clocks plus one
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0004;
    // strobe pulse widths in clocks; a one-clock pulse is lost behind a
    // three-flop agreement filter on the far end
    localparam int unsigned STB_CLK = 2;
endpackage
`default_nettype wire

/* File: verilog/ubb_if.sv */
// Purpose: pins between the bit-bang port and the external logic
// Assumes: each pin resolved by the testbench from the output enables
// Notes: oe high means the port drives that pin
`timescale 1ns/1ps
`default_nettype none
interface ubb_if;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_in;
    logic pin_sample_strobe_n;
    logic output_update_strobe_n;
    modport port_end (
        output pin_out, pin_oe, pin_sample_strobe_n, output_update_strobe_n,
        input pin_in
    );
    modport logic_end (
        input pin_out, pin_oe, pin_sample_strobe_n, output_update_strobe_n,
        output pin_in
    );
endinterface
`default_nettype wire

/* File: verilog/ubb_sync3.sv */
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: input from outside the clock domain
// Notes: output updates once the second and third flops agree
`timescale 1ns/1ps
`default_nettype none
module ubb_sync3 #(
    parameter int unsigned W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] agree;
    logic [W-1:0] nxt_q_ff;
    assign agree = ~(s2_ff ^ s3_ff);
    assign nxt_q_ff = (agree & s3_ff) | (~agree & q_ff);
    assign q = q_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
            s3_ff <= INIT;
            q_ff <= INIT;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff <= nxt_q_ff;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/ubb_port.sv */
// Purpose: device end of the bit-bang parallel port
// Assumes: rx bytes offered by valid/ready; tx samples taken by valid/ready
// Notes: mode and mask load on a mode-setup pulse; baud divisor is an input
//
// Summary of operation
// R01: async mode drives each rx byte out
// R02: per-bit direction mask selects outputs
// R03: async outputs change on byte plus tick
// R04: async mode pulses both strobes per access
// R05: sync mode updates pins per byte, strobes
// R06: sync samples only with a port write
// R07: sync stalls while tx sample path full
// R08: sync samples first, then drives output
// R09: host sends extra byte to read back
// R10: mode code 1 selects async bit-bang
// R11: mode code 4 selects sync bit-bang
// R12: sync cycle sample, strobe, drive, setup, pulse
// R13: sample strobe rising edge marks capture
// R14: mask held until next mode-setup
// R15: all-input port still needs written bytes
// R16: strobes active low, idle high
`timescale 1ns/1ps
`default_nettype none
module ubb_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mode_load,
    input wire logic [7:0] mode_code,
    input wire logic [7:0] dir_mask,
    input wire logic [15:0] baud_div,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic [7:0] mode_now,
    ubb_if.port_end pins
);
    // ****************************************
    // state
    // ****************************************
    typedef enum {ST_IDLE, ST_SAMPLE, ST_DRIVE, ST_SETUP, ST_WSTB,
        ST_ASTB} ubb_state_e;
    ubb_state_e state_ff;
    ubb_state_e nxt_state_ff;
    logic [7:0] mode_ff;
    logic [7:0] dir_ff;
    logic [7:0] out_ff;
    logic [7:0] hold_ff;
    logic [7:0] tx_data_ff;
    logic tx_valid_ff;
    logic rstb_n_ff;
    logic wstb_n_ff;
    logic [15:0] baud_cnt_ff;
    logic [7:0] pin_sync;
    logic is_async;
    logic is_sync;
    logic tick;
    logic take_byte;
    logic tx_room;
    logic [7:0] step_ff;
    logic [7:0] step_load;
    logic [7:0] stb_last;
    logic [7:0] setup_last;
    logic step_done;
    logic state_move;
    logic leave_sample;
    logic leave_astb;

    ubb_sync3 #(.W(8), .INIT(8'hff)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d(pins.pin_in),
        .q(pin_sync)
    );

    // ****************************************
    // decode
    // ****************************************
    assign is_async = (mode_ff == ubb_pkg::MODE_ASYNC); // R10
    assign is_sync = (mode_ff == ubb_pkg::MODE_SYNC); // R11
    assign tick = (baud_cnt_ff == 16'h0000);
    // one sample slot; it must be empty or draining this cycle
    assign tx_room = !tx_valid_ff || tx_ready; // R07
    assign take_byte = (state_ff == ST_IDLE) && rx_valid && !mode_load &&
        ((is_async && tick) || (is_sync && tx_room)); // R03 R07
    assign rx_ready = take_byte;
    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;
    assign mode_now = mode_ff;
    // every timed state counts down to zero and then moves on
    assign stb_last = 8'(ubb_pkg::STB_CLK - 1); // R16
    assign setup_last = 8'(ubb_pkg::SETUP_CLK - 1); // R12
    assign step_done = (step_ff == 8'h00);
    assign state_move = (nxt_state_ff != state_ff);
    assign step_load = (nxt_state_ff == ST_SETUP) ? setup_last : stb_last;
    assign leave_sample = (state_ff == ST_SAMPLE) && step_done; // R13
    assign leave_astb = (state_ff == ST_ASTB) && step_done; // R04
    // value shown only where the mask marks an output
    assign pins.pin_out = out_ff & dir_ff; // R02 R15
    assign pins.pin_oe = dir_ff; // R02
    assign pins.pin_sample_strobe_n = rstb_n_ff; // R16
    assign pins.output_update_strobe_n = wstb_n_ff; // R16

    always_comb begin
        nxt_state_ff = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take_byte && is_sync) begin
                    nxt_state_ff = ST_SAMPLE;
                end else if (take_byte) begin
                    nxt_state_ff = ST_ASTB;
                end
            end
            ST_SAMPLE: begin
                if (step_done) begin
                    nxt_state_ff = ST_DRIVE;
                end
            end
            ST_DRIVE: nxt_state_ff = ST_SETUP;
            ST_SETUP: begin
                if (step_done) begin
                    nxt_state_ff = ST_WSTB;
                end
            end
            ST_WSTB: begin
                if (step_done) begin
                    nxt_state_ff = ST_IDLE;
                end
            end
            ST_ASTB: begin
                if (step_done) begin
                    nxt_state_ff = ST_IDLE;
                end
            end
            default: nxt_state_ff = ST_IDLE;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_ff <= ubb_pkg::MODE_RESET;
            dir_ff <= ubb_pkg::DIR_RESET;
            baud_cnt_ff <= 16'h0000;
        end else begin
            if (mode_load && state_ff == ST_IDLE) begin
                mode_ff <= mode_code; // R10 R11
                dir_ff <= dir_mask; // R14
            end
            if (tick || take_byte) begin
                baud_cnt_ff <= baud_div;
            end else begin
                baud_cnt_ff <= baud_cnt_ff - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            out_ff <= ubb_pkg::OUT_RESET;
            hold_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state_ff;
            if (take_byte) begin
                hold_ff <= rx_data;
            end
            if (take_byte && is_async) begin
                out_ff <= rx_data; // R01 R03
            end else if (state_ff == ST_DRIVE) begin
                out_ff <= hold_ff; // R05 R08
            end
        end
    end

    // ****************************************
    // step timer
    // ****************************************
    // strobes stand two clocks so a filtered far end still sees them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_ff <= 8'h00;
        end else if (state_move) begin
            step_ff <= step_load;
        end else if (!step_done) begin
            step_ff <= step_ff - 8'h01;
        end
    end

    // sample is pushed at the edge where the sample strobe rises
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
        end else begin
            if (leave_sample ||
                (leave_astb && tx_room)) begin
                tx_valid_ff <= 1'b1; // R06 R08
                tx_data_ff <= pin_sync; // R08
            end else if (tx_ready) begin
                tx_valid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstb_n_ff <= 1'b1;
            wstb_n_ff <= 1'b1;
        end else begin
            // low while sampling, rises at capture
            rstb_n_ff <= !(nxt_state_ff == ST_SAMPLE ||
                nxt_state_ff == ST_ASTB); // R12 R13 R04
            wstb_n_ff <= !(nxt_state_ff == ST_WSTB ||
                nxt_state_ff == ST_ASTB); // R05 R12 R04
        end
    end
endmodule
`default_nettype wire

/* File: verilog/ubb_ext.sv */
// Purpose: external logic end: drives inputs, counts strobes
// Assumes: pins resolved outside from output enables
// Notes: latches the driven pins on each update strobe rise
`timescale 1ns/1ps
`default_nettype none
module ubb_ext (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] drive_value,
    output logic [7:0] seen_out,
    output logic [7:0] seen_oe,
    output logic [15:0] update_count,
    output logic [15:0] sample_count,
    ubb_if.logic_end pins
);
    logic [7:0] wstb_s;
    logic [7:0] rstb_s;
    logic wprev_ff;
    logic rprev_ff;
    logic [7:0] seen_out_ff;
    logic [7:0] seen_oe_ff;
    logic [15:0] upd_ff;
    logic [15:0] smp_ff;
    logic [7:0] out_s;
    logic [7:0] oe_s;

    ubb_sync3 #(.W(8), .INIT(8'hff)) u_s_w (
        .clk(clk), .nrst(nrst),
        .d({6'h00, pins.pin_sample_strobe_n, pins.output_update_strobe_n}),
        .q(wstb_s)
    );
    ubb_sync3 #(.W(8), .INIT(8'h00)) u_s_o (
        .clk(clk), .nrst(nrst), .d(pins.pin_out), .q(out_s)
    );
    ubb_sync3 #(.W(8), .INIT(8'h00)) u_s_e (
        .clk(clk), .nrst(nrst), .d(pins.pin_oe), .q(oe_s)
    );
    assign rstb_s = wstb_s;
    // inputs are only meaningful where the port does not drive
    assign pins.pin_in = drive_value; // R15
    assign seen_out = seen_out_ff;
    assign seen_oe = seen_oe_ff;
    assign update_count = upd_ff;
    assign sample_count = smp_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wprev_ff <= 1'b1;
            rprev_ff <= 1'b1;
            seen_out_ff <= 8'h00;
            seen_oe_ff <= 8'h00;
            upd_ff <= 16'h0000;
            smp_ff <= 16'h0000;
        end else begin
            wprev_ff <= wstb_s[0];
            rprev_ff <= rstb_s[1];
            if (!wprev_ff && wstb_s[0]) begin
                upd_ff <= upd_ff + 16'h0001;
                seen_out_ff <= out_s;
                seen_oe_ff <= oe_s;
            end
            if (!rprev_ff && rstb_s[1]) begin
                smp_ff <= smp_ff + 16'h0001; // R13
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/ubb_props.sv */
// Purpose: wire-level checks between the bit-bang port and external logic
// Assumes: one clock domain, nrst asynchronous active low
// Notes: sees the shared pins only, not the host-side streams
`timescale 1ns/1ps
`default_nettype none
module ubb_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_in,
    input wire logic pin_sample_strobe_n,
    input wire logic output_update_strobe_n
);
    wire sn = pin_sample_strobe_n;
    wire un = output_update_strobe_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ****
    // sync walk pieces
    // ****
    sequence s_sample;
        !sn && un ##1 sn;
    endsequence
    sequence s_update;
        un ##1 (!un) [*2] ##1 un;
    endsequence
    property p_sync_walk;
        s_sample |=> s_update;
    endproperty
    a_sync_walk: assert property (p_sync_walk)
        else $error("update strobe misplaced after sample");
    // sample cycle must leave the pins untouched
    property p_sample_first;
        !sn && un |=> $stable(pin_out);
    endproperty
    a_sample_first: assert property (p_sample_first)
        else $error("pins moved during sample");
    property p_sample_one;
        $fell(sn) |=> !sn ##1 sn;
    endproperty
    a_sample_one: assert property (p_sample_one)
        else $error("sample strobe too long");
    property p_update_one;
        $fell(un) |=> !un ##1 un;
    endproperty
    a_update_one: assert property (p_update_one)
        else $error("update strobe too long");
    property p_masked;
        (pin_out & ~pin_oe) == 8'h00;
    endproperty
    a_masked: assert property (p_masked)
        else $error("input pin driven");
    // a mask load may move the pins without any access
    property p_change_cause;
        $changed(pin_out) && $stable(pin_oe) |-> !sn || !$past(sn, 2);
    endproperty
    a_change_cause: assert property (p_change_cause)
        else $error("pins changed without access");
    property p_update_after_sample;
        $fell(un) |-> $fell(sn) || !$past(sn, 3);
    endproperty
    a_update_after_sample: assert property (p_update_after_sample)
        else $error("update strobe without sample");
    property p_sample_has_update;
        $fell(sn) |-> ##[0:4] !un;
    endproperty
    a_sample_has_update: assert property (p_sample_has_update)
        else $error("sample without update");
    property p_oe_idle;
        $changed(pin_oe) |-> sn && un;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("direction changed during access");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench for both ends of the bit-bang port
// Assumes: 20 MHz clock; fixed waits follow the handover walk
// Notes: pins resolved here, the port drives where oe is high
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [7:0] c, m, e, d, s;
    } ubb_row_s;
    logic clk = 1'h0, nrst = 1'h0, ld = 1'h0, rxv = 1'h0, txr = 1'h1;
    logic rxr, txv;
    logic [7:0] code = 8'h00, mask = 8'h00, ext = 8'h00, rxd = 8'h00;
    logic [7:0] txd, mnow, so, soe;
    logic [15:0] uc, sc;
    logic [7:0] q[$];
    int miscompares = 0, checked = 0;
    ubb_row_s rows [9] = '{
        '{8'h04, 8'hff, 8'h00, 8'h55, 8'hff},
        '{8'h04, 8'hff, 8'h00, 8'haa, 8'h55},
        '{8'h04, 8'hff, 8'h00, 8'haa, 8'haa},
        '{8'h04, 8'h0f, 8'ha0, 8'h3c, 8'haa},
        '{8'h04, 8'h0f, 8'ha0, 8'h3c, 8'hac},
        '{8'h04, 8'h00, 8'h5a, 8'hff, 8'h5a},
        '{8'h04, 8'h00, 8'h5a, 8'h00, 8'h5a},
        '{8'h01, 8'hff, 8'h00, 8'hc3, 8'h00},
        '{8'h01, 8'hf0, 8'h0f, 8'h96, 8'h00}
    };
    ubb_if bus();
    wire logic [7:0] drv = (bus.pin_out & bus.pin_oe) | (ext & ~bus.pin_oe);
    wire logic sn = bus.pin_sample_strobe_n;
    wire logic un = bus.output_update_strobe_n;
    ubb_port u_ubb_port (.clk(clk), .nrst(nrst), .mode_load(ld),
        .mode_code(code), .dir_mask(mask),
        .baud_div(ubb_pkg::BAUD_DIV_RESET), .rx_valid(rxv), .rx_data(rxd),
        .rx_ready(rxr), .tx_valid(txv), .tx_data(txd), .tx_ready(txr),
        .mode_now(mnow), .pins(bus.port_end));
    ubb_ext u_ubb_ext (.clk(clk), .nrst(nrst), .drive_value(drv),
        .seen_out(so), .seen_oe(soe), .update_count(uc),
        .sample_count(sc), .pins(bus.logic_end));
    ubb_props u_ubb_props (.clk(clk), .nrst(nrst), .pin_out(bus.pin_out),
        .pin_oe(bus.pin_oe), .pin_in(bus.pin_in),
        .pin_sample_strobe_n(sn), .output_update_strobe_n(un));
    always #25 clk = ~clk;
    always @(posedge clk) if (txv && txr) q.push_back(txd);
    // ****
    // tasks
    // ****
    task automatic chk(input logic [7:0] g, input logic [7:0] w);
        checked++;
        if (g !== w) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, g, w);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic setm(input logic [7:0] c, input logic [7:0] m);
        code = c;
        mask = m;
        ld = 1'h1;
        cyc(1);
        ld = 1'h0;
        cyc(1);
        chk(mnow, c);
        chk(bus.pin_oe, m);
    endtask
    task automatic send(input logic [7:0] d);
        rxd = d;
        rxv = 1'h1;
        @(negedge clk);
        repeat (400) if (rxr !== 1'h1) @(negedge clk);
        chk({7'h00, rxr}, 8'h01);
        cyc(1);
        rxv = 1'h0;
    endtask
    // leaves the byte offered so a stalled byte can be taken later
    task automatic refuse(input logic [7:0] d);
        logic [7:0] p;
        p = bus.pin_out;
        rxd = d;
        rxv = 1'h1;
        cyc(20);
        chk({7'h00, rxr}, 8'h00);
        chk(bus.pin_out, p);
    endtask
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        cyc(11);
        chk({6'h00, sn, un}, 8'h03);
        chk(bus.pin_oe, ubb_pkg::DIR_RESET);
        cyc(1);
        nrst = 1'h1;
        cyc(2);
        foreach (rows[i]) begin
            ext = rows[i].e;
            if (rows[i].c !== mnow || rows[i].m !== bus.pin_oe)
                setm(rows[i].c, rows[i].m);
            // covers the three-flop input path before sampling
            cyc(4);
            send(rows[i].d);
            cyc(12);
            chk(bus.pin_out, rows[i].d & rows[i].m);
            chk(so, rows[i].d & rows[i].m);
            chk(soe, rows[i].m);
            chk(uc[7:0], 8'(i + 1));
            chk(sc[7:0], 8'(i + 1));
            if (rows[i].c == ubb_pkg::MODE_SYNC) begin
                chk(8'(q.size()), 8'h01);
                chk(q.pop_front(), rows[i].s);
            end
            q.delete();
        end
        cyc(30);
        chk(bus.pin_out, 8'h90);
        chk(uc[7:0], 8'h09);
        setm(ubb_pkg::MODE_SYNC, 8'hff);
        cyc(30);
        chk(8'(q.size()), 8'h00);
        chk(sc[7:0], 8'h09);
        txr = 1'h0;
        send(8'h11);
        cyc(8);
        refuse(8'h22);
        txr = 1'h1;
        send(8'h22);
        cyc(8);
        chk(bus.pin_out, 8'h22);
        chk(q.pop_front(), 8'h96);
        chk(q.pop_front(), 8'h11);
        setm(ubb_pkg::MODE_RESET, 8'hff);
        refuse(8'h33);
        rxv = 1'h0;
        cyc(2);
        // reset in mid-run clears mode, mask and the far-end counters
        nrst = 1'h0;
        cyc(2);
        chk(mnow, ubb_pkg::MODE_RESET);
        chk(bus.pin_oe, ubb_pkg::DIR_RESET);
        chk(bus.pin_out, 8'h00);
        chk(uc[7:0], 8'h00);
        nrst = 1'h1;
        cyc(2);
        chk({6'h00, sn, un}, 8'h03);
        test_done();
    end
endmodule
`default_nettype wire
